// >>> design/adcc_aux_decimator.sv
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "adcc_defines.svh"

// Summary of operation
// - Auxiliary filter turns the modulator bitstream into 24-bit results.
// - First stage is sinc3 decimating by 64, 128 or 512.
// - Second stage is sinc1 decimating the 100 SPS stream by ten.
// - Second stage is bypassed for 800, 400 and 100 SPS.
// - Total decimation is first ratio times second ratio when used.
// - Rate field 00=10, 01=100, 10=400, 11=800 SPS; reset 00.
// - One modulator bit enters the filter every 144 clock cycles.
// - All rates come from clock division and scale with the clock.
// - Mode register bit 6 picks continuous or pulse conversion.
// - Continuous mode converts back to back until stopped.
// - Pulse mode does one conversion per start, then halts.
// - Start and stop opcodes act at the seventh falling serial edge.
// - Opcode 08h or 09h starts the main converter.
// - Opcode 0Ah or 0Bh stops the main converter.
// - Opcode 0Ch or 0Dh starts the auxiliary converter.
// - Opcode 0Eh or 0Fh stops the auxiliary converter.
// - Start pin and ready output concern only the main converter.
// - Pulse mode drives ready high within 2 clocks of start.
// - Stop 16 clocks before ready falls halts further conversions.
// - Stop after ready falls lets the running conversion complete.
// - Ready goes high on start or restart, low on new data.
// - Auxiliary runs by command only, start to stop, independently.
// - Pulse mode ignores a stop during an ongoing conversion.
module adcc_aux_decimator
  import adcc_pkg::*;
#(
  parameter int ACC_W = 28,
  parameter int MOD_DIV = `ADCC_MOD_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire adcc_avs_req_t avsReq,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic startPin,
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdOpcode,
  input wire logic auxModBit,
  input wire logic priDataReady,
  output logic priConvStart,
  output logic priRunning,
  output logic resultReadyN,
  output logic auxRunning,
  output logic auxResultValid,
  output logic [23:0] auxResult
);

  logic ack_r;
  logic modePulse_r;
  logic [1:0] rate_r;
  logic [1:0] startSync_r;
  logic startLast_r;
  logic startRise;
  logic startFall;
  logic priStartCmd;
  logic priStopCmd;
  logic auxStartCmd;
  logic auxStopCmd;
  logic startEvt;
  logic stopEvt;
  adcc_pri_state_t priState_r;
  logic stopPending_r;
  logic readyN_r;
  logic auxRun_r;
  logic [7:0] modDiv_r;
  logic modStrobe;
  logic [9:0] decCnt_r;
  logic [9:0] ratio;
  logic decim;
  logic filtClear;
  logic [ACC_W-1:0] integ_r [3];
  logic [ACC_W-1:0] integSrc [4];
  logic [ACC_W-1:0] combDly_r [3];
  logic [ACC_W-1:0] combOut [4];
  logic [ACC_W-1:0] norm;
  logic [ACC_W-1:0] centered;
  logic [23:0] s1Out;
  logic [1:0] s1Fill_r;
  logic s1Valid;
  logic signed [ACC_W-1:0] s2Acc_r;
  logic signed [ACC_W-1:0] s2Sum;
  logic signed [41:0] s2Scaled;
  logic [3:0] s2Cnt_r;
  logic [23:0] auxResult_r;
  logic auxValid_r;
  logic rateWrite;
  logic avsAccept;

  // Avalon slave: waitrequest drops one cycle after a request appears.
  assign avsWaitRequest = (avsReq.read | avsReq.write) & ~ack_r;
  assign avsAccept = (avsReq.read | avsReq.write) & ack_r;
  assign rateWrite = avsAccept & avsReq.write &
    (avsReq.address == `ADCC_OFF_AUXCFG);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avsReq.read | avsReq.write) & ~ack_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modePulse_r <= `ADCC_MODE_RST;
      rate_r <= `ADCC_RATE_RST;
    end else if (avsAccept && avsReq.write) begin
      if (avsReq.address == `ADCC_OFF_MODE) begin
        modePulse_r <= avsReq.writedata[`ADCC_MODE_PULSE_BIT];
      end
      if (avsReq.address == `ADCC_OFF_AUXCFG) begin
        rate_r <= avsReq.writedata[`ADCC_AUXCFG_RATE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avsReadData <= 32'h0000_0000;
    end else if ((avsReq.read | avsReq.write) && !ack_r) begin
      avsReadData <= 32'h0000_0000;
      unique case (avsReq.address)
        `ADCC_OFF_MODE: avsReadData[`ADCC_MODE_PULSE_BIT] <= modePulse_r;
        `ADCC_OFF_AUXCFG: avsReadData[1:0] <= rate_r;
        `ADCC_OFF_STATUS: begin
          avsReadData[`ADCC_ST_PRI_RUN_BIT] <= priState_r == PRI_CONV;
          avsReadData[`ADCC_ST_AUX_RUN_BIT] <= auxRun_r;
          avsReadData[`ADCC_ST_READY_N_BIT] <= readyN_r;
        end
        `ADCC_OFF_AUXDATA: avsReadData[23:0] <= auxResult_r;
        default: avsReadData <= 32'h0000_0000;
      endcase
    end
  end

  // Start pin is asynchronous; the edge detector reads only the second stage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      startSync_r <= 2'b00;
      startLast_r <= 1'b0;
    end else begin
      startSync_r <= {startSync_r[0], startPin};
      startLast_r <= startSync_r[1];
    end
  end

  assign startRise = startSync_r[1] & ~startLast_r;
  assign startFall = ~startSync_r[1] & startLast_r;

  // The strobe marks the seventh falling serial edge of the opcode byte.
  assign priStartCmd = cmdStrobe &
    (cmdOpcode[7:1] == `ADCC_OP_PRI_START);
  assign priStopCmd = cmdStrobe &
    (cmdOpcode[7:1] == `ADCC_OP_PRI_STOP);
  assign auxStartCmd = cmdStrobe &
    (cmdOpcode[7:1] == `ADCC_OP_AUX_START);
  assign auxStopCmd = cmdStrobe &
    (cmdOpcode[7:1] == `ADCC_OP_AUX_STOP);
  assign startEvt = startRise | priStartCmd;
  assign stopEvt = startFall | priStopCmd;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      priState_r <= PRI_IDLE;
      stopPending_r <= 1'b0;
    end else begin
      unique case (priState_r)
        PRI_IDLE: begin
          stopPending_r <= 1'b0;
          if (startEvt) begin
            priState_r <= PRI_CONV;
          end
        end
        PRI_CONV: begin
          if (startEvt) begin
            stopPending_r <= 1'b0;
          end else if (priDataReady) begin
            if (modePulse_r || stopPending_r || stopEvt) begin
              priState_r <= PRI_IDLE;
            end
          end else if (stopEvt && !modePulse_r) begin
            stopPending_r <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readyN_r <= 1'b1;
      priConvStart <= 1'b0;
    end else begin
      priConvStart <= startEvt;
      if (startEvt) begin
        readyN_r <= 1'b1;
      end else if (priDataReady && priState_r == PRI_CONV) begin
        readyN_r <= 1'b0;
      end
    end
  end

  assign resultReadyN = readyN_r;
  assign priRunning = priState_r == PRI_CONV;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      auxRun_r <= 1'b0;
    end else if (auxStartCmd) begin
      auxRun_r <= 1'b1;
    end else if (auxStopCmd) begin
      auxRun_r <= 1'b0;
    end
  end

  assign auxRunning = auxRun_r;
  assign filtClear = ~auxRun_r | auxStartCmd | rateWrite;

  // Input bit rate is the master clock divided down; nothing else sets it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modDiv_r <= 8'h00;
    end else if (filtClear || modDiv_r == 8'(MOD_DIV - 1)) begin
      modDiv_r <= 8'h00;
    end else begin
      modDiv_r <= modDiv_r + 8'h01;
    end
  end

  assign modStrobe = ~filtClear & (modDiv_r == 8'(MOD_DIV - 1));

  always_comb begin
    unique case (rate_r)
      `ADCC_RATE_800: ratio = `ADCC_R_64;
      `ADCC_RATE_400: ratio = `ADCC_R_128;
      default: ratio = `ADCC_R_512;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      decCnt_r <= 10'h000;
    end else if (filtClear) begin
      decCnt_r <= 10'h000;
    end else if (modStrobe) begin
      decCnt_r <= (decCnt_r == ratio - 10'h001) ? 10'h000 :
        decCnt_r + 10'h001;
    end
  end

  assign decim = modStrobe & (decCnt_r == ratio - 10'h001);
  assign integSrc[0] = {{(ACC_W-1){1'b0}}, auxModBit};
  assign combOut[0] = integ_r[2];

  // Integrators at the input rate, combs at the decimated rate.
  for (genvar i = 0; i < 3; i++) begin : g_sinc3
    assign integSrc[i+1] = integ_r[i];
    assign combOut[i+1] = combOut[i] - combDly_r[i];
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        integ_r[i] <= '0;
        combDly_r[i] <= '0;
      end else if (filtClear) begin
        integ_r[i] <= '0;
        combDly_r[i] <= '0;
      end else begin
        if (modStrobe) begin
          integ_r[i] <= integ_r[i] + integSrc[i];
        end
        if (decim) begin
          combDly_r[i] <= combOut[i];
        end
      end
    end
  end

  // Scale every ratio to a full scale of 2^27, then centre on zero.
  always_comb begin
    unique case (rate_r)
      `ADCC_RATE_800: norm = combOut[3] << 9;
      `ADCC_RATE_400: norm = combOut[3] << 6;
      default: norm = combOut[3];
    endcase
    centered = norm - (ACC_W'(1) << 26);
    if (!centered[27] && centered[26]) begin
      s1Out = 24'h7F_FFFF;
    end else begin
      s1Out = centered[26:3];
    end
  end

  // The first two comb outputs hold partial history and are dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Fill_r <= 2'b00;
    end else if (filtClear) begin
      s1Fill_r <= 2'b00;
    end else if (decim && s1Fill_r != 2'b10) begin
      s1Fill_r <= s1Fill_r + 2'b01;
    end
  end

  assign s1Valid = decim & (s1Fill_r == 2'b10);
  assign s2Sum = s2Acc_r + ACC_W'(signed'(s1Out));
  assign s2Scaled = 42'(s2Sum) * 42'sd6554;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s2Acc_r <= '0;
      s2Cnt_r <= 4'h0;
    end else if (filtClear) begin
      s2Acc_r <= '0;
      s2Cnt_r <= 4'h0;
    end else if (s1Valid && rate_r == `ADCC_RATE_10) begin
      if (s2Cnt_r == `ADCC_R2 - 4'h1) begin
        s2Acc_r <= '0;
        s2Cnt_r <= 4'h0;
      end else begin
        s2Acc_r <= s2Sum;
        s2Cnt_r <= s2Cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      auxResult_r <= 24'h00_0000;
      auxValid_r <= 1'b0;
    end else begin
      auxValid_r <= 1'b0;
      if (s1Valid && rate_r != `ADCC_RATE_10) begin
        auxResult_r <= s1Out;
        auxValid_r <= 1'b1;
      end else if (s1Valid && s2Cnt_r == `ADCC_R2 - 4'h1) begin
        auxResult_r <= s2Scaled[39:16];
        auxValid_r <= 1'b1;
      end
    end
  end

  assign auxResult = auxResult_r;
  assign auxResultValid = auxValid_r;

  // Checking helpers.
  logic [7:0] modGap_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modGap_r <= 8'h00;
    end else if (modStrobe || filtClear) begin
      modGap_r <= 8'h00;
    end else begin
      modGap_r <= modGap_r + 8'h01;
    end
  end

  mod_spacing_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    modStrobe |-> modGap_r == 8'(MOD_DIV - 1))
    else $error("modulator strobe spacing wrong");

  ready_high_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    startEvt && modePulse_r |-> ##[1:2] resultReadyN)
    else $error("ready not high after start");

  ready_low_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priDataReady && priRunning && !startEvt |=> !resultReadyN)
    else $error("ready not low on new data");

  pulse_halt_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priDataReady && priRunning && modePulse_r && !startEvt
    |=> !priRunning)
    else $error("pulse mode did not halt");

  cont_run_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priRunning && !modePulse_r && !stopEvt && !stopPending_r
    && !startEvt |=> priRunning)
    else $error("continuous mode stopped unprompted");

  pulse_stop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    priRunning && modePulse_r && stopEvt && !priDataReady
    |=> priRunning)
    else $error("pulse mode honoured a stop");

  stop_pending_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stopPending_r && priDataReady && !startEvt |=> !priRunning)
    else $error("pending stop not honoured");

  aux_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !auxRun_r |=> !auxResultValid)
    else $error("aux result while stopped");

  opcode_dec_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cmdStrobe && cmdOpcode[7:1] == 7'h04 |=> priConvStart && priRunning)
    else $error("start opcode not decoded");

  wait_ack_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(avsReq.read) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("waitrequest timing wrong");

  cont_cover: cover property (@(posedge core_clk) disable iff (!rst_n)
    priRunning && !modePulse_r && priDataReady ##1 priRunning);
  pulse_cover: cover property (@(posedge core_clk) disable iff (!rst_n)
    modePulse_r && priRunning ##1 !priRunning);
  aux10_cover: cover property (@(posedge core_clk) disable iff (!rst_n)
    auxResultValid && rate_r == `ADCC_RATE_10);
  aux800_cover: cover property (@(posedge core_clk) disable iff (!rst_n)
    auxResultValid && rate_r == `ADCC_RATE_800);

endmodule // adcc_aux_decimator

// >>> include/adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define ADCC_OFF_MODE 4'h0
`define ADCC_OFF_AUXCFG 4'h4
`define ADCC_OFF_STATUS 4'h8
`define ADCC_OFF_AUXDATA 4'hC

// Field positions.
`define ADCC_MODE_PULSE_BIT 6
`define ADCC_AUXCFG_RATE_LSB 0
`define ADCC_ST_PRI_RUN_BIT 0
`define ADCC_ST_AUX_RUN_BIT 1
`define ADCC_ST_READY_N_BIT 2

// Reset values.
`define ADCC_MODE_RST 1'b0
`define ADCC_RATE_RST 2'b00

// Rate field encodings.
`define ADCC_RATE_10 2'b00
`define ADCC_RATE_100 2'b01
`define ADCC_RATE_400 2'b10
`define ADCC_RATE_800 2'b11

// First stage ratios and second stage ratio.
`define ADCC_R_64 10'd64
`define ADCC_R_128 10'd128
`define ADCC_R_512 10'd512
`define ADCC_R2 4'd10

// Opcodes with the low bit ignored.
`define ADCC_OP_PRI_START 7'h04
`define ADCC_OP_PRI_STOP 7'h05
`define ADCC_OP_AUX_START 7'h06
`define ADCC_OP_AUX_STOP 7'h07

// Nominal master clock in Hz, then timing in master clock cycles.
`define ADCC_NOM_CLK_HZ 7372800
`define ADCC_MOD_DIV 144
`define ADCC_READY_MAX_CLK 2
`define ADCC_STOP_SETUP_CLK 16

`endif

// >>> include/adcc_pkg.sv
package adcc_pkg;

  typedef enum logic [1:0] {
    PRI_IDLE = 2'b01,
    PRI_CONV = 2'b10
  } adcc_pri_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } adcc_avs_req_t;

endpackage

// >>> sim/adcc_host_model.sv
`timescale 1ns/1ns
module adcc_host_model #(
  parameter int MOD_DIV = 144
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic startPin,
  output logic cmdStrobe,
  output logic [7:0] cmdOpcode,
  output logic priDataReady,
  output logic auxModBit
);
  int modCnt;

  initial begin
    startPin = 1'b0;
    cmdStrobe = 1'b0;
    cmdOpcode = 8'h00;
    priDataReady = 1'b0;
    auxModBit = 1'b0;
    modCnt = 0;
  end

  // Bit density of one half, so a settled result sits at mid scale.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modCnt <= 0;
    end else if (modCnt == MOD_DIV - 1) begin
      modCnt <= 0;
      auxModBit <= ~auxModBit;
    end else begin
      modCnt <= modCnt + 1;
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic send_cmd(input logic [6:0] op, input logic lowBit);
    @(posedge core_clk);
    cmdStrobe <= 1'b1;
    cmdOpcode <= {op, lowBit};
    @(posedge core_clk);
    cmdStrobe <= 1'b0;
    // A released opcode bus never keeps showing the last command.
    cmdOpcode <= ~{op, lowBit};
  endtask

  task automatic data_ready();
    @(posedge core_clk);
    priDataReady <= 1'b1;
    @(posedge core_clk);
    priDataReady <= 1'b0;
  endtask

  task automatic pin_pulse();
    @(posedge core_clk);
    startPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    startPin <= 1'b0;
  endtask
endmodule // adcc_host_model

// >>> sim/testbench.sv
`timescale 1ns/1ns
`include "adcc_defines.svh"
module testbench
  import adcc_pkg::*;
;
  localparam int MODDIV = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  adcc_avs_req_t avsReq = '0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic startPin;
  logic cmdStrobe;
  logic [7:0] cmdOpcode;
  logic auxModBit;
  logic priDataReady;
  logic priConvStart;
  logic priRunning;
  logic resultReadyN;
  logic auxRunning;
  logic auxResultValid;
  logic [23:0] auxResult;
  logic [31:0] rd;
  int n;
  int fail_count = 0;
  int compares = 0;
  logic [1:0] rates [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
  int ratio [4] = '{64, 128, 512, 5120};

  always #20 core_clk = ~core_clk;

  adcc_aux_decimator #(.MOD_DIV(MODDIV)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .avsReq(avsReq),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .startPin(startPin), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
    .auxModBit(auxModBit), .priDataReady(priDataReady),
    .priConvStart(priConvStart), .priRunning(priRunning),
    .resultReadyN(resultReadyN), .auxRunning(auxRunning),
    .auxResultValid(auxResultValid), .auxResult(auxResult)
  );

  adcc_host_model #(.MOD_DIV(MODDIV)) hostModel (
    .core_clk(core_clk), .rst_n(rst_n), .startPin(startPin),
    .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
    .priDataReady(priDataReady), .auxModBit(auxModBit)
  );

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic avs_xfer(input logic wr, input logic [3:0] a,
                          input logic [31:0] d);
    int k;
    @(posedge core_clk);
    avsReq.read <= ~wr;
    avsReq.write <= wr;
    avsReq.address <= a;
    avsReq.writedata <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 20);
    chk("bus answer", {31'h0, avsWaitRequest}, 32'h0000_0000);
    rd = avsReadData;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask

  task automatic pri_chk(input logic run, input logic rdyN);
    #1;
    chk("priRunning", {31'h0, priRunning}, {31'h0, run});
    chk("resultReadyN", {31'h0, resultReadyN}, {31'h0, rdyN});
  endtask

  task automatic wait_valid();
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (auxResultValid !== 1'b1 && n < 30000);
  endtask

  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    $display("unexpected run length: expected end seen timeout");
    final_report();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    pri_chk(1'b0, 1'b1);
    chk("auxRunning", {31'h0, auxRunning}, 32'h0000_0000);
    avs_xfer(1'b0, `ADCC_OFF_MODE, 32'h0000_0000);
    chk("mode reset", rd, 32'h0000_0000);
    avs_xfer(1'b0, `ADCC_OFF_AUXCFG, 32'h0000_0000);
    chk("rate reset", rd, 32'h0000_0000);
    avs_xfer(1'b1, 4'h1, 32'hFFFF_FFFF);
    avs_xfer(1'b0, 4'h1, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    avs_xfer(1'b1, `ADCC_OFF_STATUS, 32'h0000_0000);
    avs_xfer(1'b0, `ADCC_OFF_STATUS, 32'h0000_0000);
    chk("status reset", rd, 32'h0000_0004);
    // Continuous mode, both opcode forms of start and stop.
    for (int i = 0; i < 2; i++) begin
      hostModel.send_cmd(`ADCC_OP_PRI_START, i[0]);
      pri_chk(1'b1, 1'b1);
      chk("priConvStart", {31'h0, priConvStart}, 32'h0000_0001);
      hostModel.data_ready();
      pri_chk(1'b1, 1'b0);
      hostModel.idle(20);
      hostModel.send_cmd(`ADCC_OP_PRI_STOP, i[0]);
      pri_chk(1'b1, 1'b0);
      hostModel.idle(20);
      hostModel.data_ready();
      pri_chk(1'b0, 1'b0);
    end
    // Pulse mode: one conversion per start, stop ignored.
    avs_xfer(1'b1, `ADCC_OFF_MODE, 32'h0000_0040);
    avs_xfer(1'b0, `ADCC_OFF_MODE, 32'h0000_0000);
    chk("mode", rd, 32'h0000_0040);
    hostModel.send_cmd(`ADCC_OP_PRI_START, 1'b1);
    pri_chk(1'b1, 1'b1);
    hostModel.idle(20);
    hostModel.send_cmd(`ADCC_OP_PRI_STOP, 1'b1);
    pri_chk(1'b1, 1'b1);
    hostModel.data_ready();
    pri_chk(1'b0, 1'b0);
    hostModel.data_ready();
    pri_chk(1'b0, 1'b0);
    hostModel.send_cmd(`ADCC_OP_AUX_START, 1'b0);
    pri_chk(1'b0, 1'b0);
    chk("auxRunning", {31'h0, auxRunning}, 32'h0000_0001);
    // Start pin in continuous mode.
    avs_xfer(1'b1, `ADCC_OFF_MODE, 32'h0000_0000);
    hostModel.pin_pulse();
    pri_chk(1'b1, 1'b1);
    hostModel.idle(20);
    hostModel.data_ready();
    pri_chk(1'b0, 1'b0);
    hostModel.pin_pulse();
    pri_chk(1'b1, 1'b1);
    hostModel.send_cmd(`ADCC_OP_PRI_STOP, 1'b0);
    hostModel.idle(20);
    hostModel.data_ready();
    pri_chk(1'b0, 1'b0);
    chk("auxRunning", {31'h0, auxRunning}, 32'h0000_0001);
    // Output spacing for every rate code.
    for (int i = 0; i < 4; i++) begin
      avs_xfer(1'b1, `ADCC_OFF_AUXCFG, {30'h0, rates[i]});
      wait_valid();
      wait_valid();
      chk("aux spacing", n, MODDIV * ratio[i]);
      chk("auxResult", {8'h00, auxResult}, 32'h0000_0000);
      avs_xfer(1'b0, `ADCC_OFF_AUXDATA, 32'h0000_0000);
      chk("aux data reg", rd, 32'h0000_0000);
    end
    for (int i = 0; i < 2; i++) begin
      hostModel.send_cmd(`ADCC_OP_AUX_STOP, i[0]);
      #1;
      chk("auxRunning", {31'h0, auxRunning}, 32'h0000_0000);
      avs_xfer(1'b0, `ADCC_OFF_STATUS, 32'h0000_0000);
      chk("status", rd, 32'h0000_0000);
      hostModel.send_cmd(`ADCC_OP_AUX_START, ~i[0]);
      #1;
      chk("auxRunning", {31'h0, auxRunning}, 32'h0000_0001);
    end
    final_report();
  end
endmodule // testbench
